// ### hw/cise_core.sv
// Instruction subset execution core with Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
module cise_core
  import cise_pkg::*;
#(
  parameter int STACK_DEPTH = 16,
  parameter int PRE_W       = 8,
  parameter int DOG_W       = 8
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic [BUS_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [BUS_DW-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [BUS_DW-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  output logic      [PC_W-1:0]   pc_out,
  output logic                   zero_flag,
  output logic                   timeout_flag,
  output logic                   powerdown_flag
);
  localparam int FILE_N = 1 << FADR_W;

  logic [DATA_W-1:0]  file_mem [FILE_N];
  logic [DATA_W-1:0]  w_reg;
  logic [LATCH_W-1:0] latch_reg;
  logic [PC_W-1:0]    pc_reg;
  logic               zero_reg;
  logic               skip_reg;
  logic               busy_reg;
  logic [PRE_W-1:0]   pre_reg;
  logic [DOG_W-1:0]   dog_reg;
  logic               timeout_reg;
  logic               powerdown_reg;
  logic               wait_reg;
  logic [BUS_DW-1:0]  readdata_reg;
  logic [BUS_DW-1:0]  rd_next;

  logic               req;
  logic               instr_hit;
  logic               file_hit;
  logic [FADR_W-1:0]  file_idx;
  logic               stall;
  logic               wr_take;
  logic               exec_go;
  cise_op_t           op_sel;
  cise_op_t           eff_op;
  logic               dest_b;
  logic [FADR_W-1:0]  faddr;
  logic [DATA_W-1:0]  fval;
  logic [DATA_W-1:0]  alu_res;
  logic               res_zero;
  logic               to_w;
  logic               to_f;

  cise_stack_if stk_if ();

  cise_stack #(
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .mclk  (mclk),
    .reset (reset),
    .sif   (stk_if.stack)
  );

  function automatic logic reg_hit(input logic [BUS_AW-1:0] a, input logic [BUS_AW-1:0] off);
    reg_hit = (a[BUS_AW-1:FILE_IDX_LSB] == off[BUS_AW-1:FILE_IDX_LSB]);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode and handshake

  assign req       = avs_read | avs_write;
  assign instr_hit = reg_hit(avs_address, OFF_INSTR);
  assign file_hit  = avs_address[FILE_SEL_BIT];
  assign file_idx  = avs_address[FILE_IDX_LSB +: FADR_W];
  // A new instruction waits out the second cycle of a two-cycle call
  assign stall     = avs_write && instr_hit && busy_reg;
  assign wr_take   = avs_write && !wait_reg;
  assign exec_go   = wr_take && instr_hit && (&avs_byteenable[1:0]);

  always_ff @(posedge mclk) begin
    if (reset) begin
      wait_reg <= 1'b1;
    end else if (!wait_reg) begin
      wait_reg <= 1'b1;
    end else if (req && !stall) begin
      wait_reg <= 1'b0;
    end
  end

  always_comb begin
    rd_next = RD_ZERO;
    if (file_hit) begin
      rd_next[DATA_W-1:0] = file_mem[file_idx];
    end else begin
      case (1'b1)
        reg_hit(avs_address, OFF_STATUS): begin
          rd_next[ST_ZERO] = zero_reg;
          rd_next[ST_PDN]  = powerdown_reg;
          rd_next[ST_TMO]  = timeout_reg;
          rd_next[ST_SKIP] = skip_reg;
          rd_next[ST_BUSY] = busy_reg;
        end
        reg_hit(avs_address, OFF_WREG):   rd_next[DATA_W-1:0] = w_reg;
        reg_hit(avs_address, OFF_LATCH):  rd_next[LATCH_W-1:0] = latch_reg;
        reg_hit(avs_address, OFF_PC):     rd_next[PC_W-1:0] = pc_reg;
        reg_hit(avs_address, OFF_TOP):    rd_next[PC_W-1:0] = stk_if.stack_top;
        reg_hit(avs_address, OFF_DOG):    rd_next[DOG_W-1:0] = dog_reg;
        default:                          rd_next = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      readdata_reg <= RD_ZERO;
    end else if (wait_reg && avs_read) begin
      readdata_reg <= rd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Instruction decode and result

  assign op_sel   = cise_op_t'(avs_writedata[OP_LSB +: OP_W]);
  // A pending skip replaces the next instruction by a no-operation
  assign eff_op   = skip_reg ? OP_NOP : op_sel;
  assign dest_b   = avs_writedata[DEST_BIT];
  assign faddr    = avs_writedata[FADR_LSB +: FADR_W];
  assign fval     = file_mem[faddr];
  assign res_zero = (alu_res == ZERO8);

  always_comb begin
    alu_res = ZERO8;
    unique case (eff_op)
      OP_INV:             alu_res = ~fval;
      OP_FDEC, OP_DSKIP:  alu_res = fval - ONE8;
      default:            alu_res = ZERO8;
    endcase
  end

  assign to_w = exec_go && !dest_b &&
                (eff_op == OP_INV || eff_op == OP_FDEC || eff_op == OP_DSKIP);
  assign to_f = exec_go && dest_b &&
                (eff_op == OP_INV || eff_op == OP_FDEC || eff_op == OP_DSKIP);

  //////////////////////////////////////////////////////////////////////////////
  // Working register and file registers

  always_ff @(posedge mclk) begin
    if (reset) begin
      w_reg <= ZERO8;
    end else if (exec_go && eff_op == OP_WCLR) begin
      w_reg <= ZERO8;
    end else if (to_w) begin
      w_reg <= alu_res;
    end else if (wr_take && !file_hit && reg_hit(avs_address, OFF_WREG) && avs_byteenable[0]) begin
      w_reg <= avs_writedata[DATA_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < FILE_N; i++) begin
        file_mem[i] <= ZERO8;
      end
    end else if (exec_go && eff_op == OP_FCLR) begin
      file_mem[faddr] <= ZERO8;
    end else if (to_f) begin
      file_mem[faddr] <= alu_res;
    end else if (wr_take && file_hit && avs_byteenable[0]) begin
      file_mem[file_idx] <= avs_writedata[DATA_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      latch_reg <= LATCH_RST;
    end else if (wr_take && !file_hit && reg_hit(avs_address, OFF_LATCH) && avs_byteenable[0]) begin
      latch_reg <= avs_writedata[LATCH_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Program counter, stack and cycle control

  assign stk_if.push      = exec_go && eff_op == OP_WCALL;
  assign stk_if.push_addr = pc_reg + PC_INC;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pc_reg <= PC_RST;
    end else if (exec_go && eff_op == OP_WCALL) begin
      pc_reg <= {latch_reg, w_reg};
    end else if (exec_go) begin
      pc_reg <= pc_reg + PC_INC;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= exec_go && eff_op == OP_WCALL;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      skip_reg <= 1'b0;
    end else if (exec_go) begin
      skip_reg <= (eff_op == OP_DSKIP) && res_zero;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Zero flag

  always_ff @(posedge mclk) begin
    if (reset) begin
      zero_reg <= Z_RST;
    end else if (exec_go) begin
      unique case (eff_op)
        OP_FCLR, OP_WCLR: zero_reg <= 1'b1;
        OP_INV, OP_FDEC:  zero_reg <= res_zero;
        default:          zero_reg <= zero_reg;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog counter, prescaler and its status flags

  always_ff @(posedge mclk) begin
    if (reset) begin
      pre_reg <= '0;
      dog_reg <= '0;
    end else if (exec_go && eff_op == OP_DOGCLR) begin
      pre_reg <= '0;
      dog_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
      if (&pre_reg) begin
        dog_reg <= dog_reg + 1'b1;
      end
    end
  end

  // Overflow drops the timeout flag; a clear in the same cycle wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      timeout_reg   <= TMO_RST;
      powerdown_reg <= PDN_RST;
    end else if (exec_go && eff_op == OP_DOGCLR) begin
      timeout_reg   <= 1'b1;
      powerdown_reg <= 1'b1;
    end else if ((&pre_reg) && (&dog_reg)) begin
      timeout_reg   <= 1'b0;
    end
  end

  assign avs_readdata    = readdata_reg;
  assign avs_waitrequest = wait_reg;
  assign pc_out          = pc_reg;
  assign zero_flag       = zero_reg;
  assign timeout_flag    = timeout_reg;
  assign powerdown_flag  = powerdown_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_dogclr;
    @(posedge mclk) disable iff (reset)
    exec_go && eff_op == OP_DOGCLR |=> dog_reg == '0 && pre_reg == '0 && timeout_reg && powerdown_reg;
  endproperty
  a_dogclr: assert property (p_dogclr) else $error("watchdog clear incomplete");

  property p_wcall_push;
    @(posedge mclk) disable iff (reset)
    exec_go && eff_op == OP_WCALL |=> stk_if.stack_top == $past(pc_reg) + PC_INC;
  endproperty
  a_wcall_push: assert property (p_wcall_push) else $error("return address not pushed");

  property p_wcall_pc;
    @(posedge mclk) disable iff (reset)
    exec_go && eff_op == OP_WCALL |=> pc_reg == {$past(latch_reg), $past(w_reg)};
  endproperty
  a_wcall_pc: assert property (p_wcall_pc) else $error("call target wrong");

  property p_wcall_cycles;
    @(posedge mclk) disable iff (reset)
    exec_go && eff_op == OP_WCALL |=> busy_reg && $stable(zero_reg) && !exec_go ##1 !busy_reg;
  endproperty
  a_wcall_cycles: assert property (p_wcall_cycles) else $error("call not two cycles");

  property p_inv;
    @(posedge mclk) disable iff (reset)
    exec_go && eff_op == OP_INV |=>
      (($past(dest_b) ? file_mem[$past(faddr)] : w_reg) == ~$past(fval));
  endproperty
  a_inv: assert property (p_inv) else $error("complement result wrong");

  property p_fclr;
    @(posedge mclk) disable iff (reset)
    exec_go && eff_op == OP_FCLR |=> file_mem[$past(faddr)] == ZERO8 && zero_reg;
  endproperty
  a_fclr: assert property (p_fclr) else $error("file clear wrong");

  property p_wclr;
    @(posedge mclk) disable iff (reset)
    exec_go && eff_op == OP_WCLR |=> w_reg == ZERO8 && zero_reg;
  endproperty
  a_wclr: assert property (p_wclr) else $error("W clear wrong");

  property p_fdec;
    @(posedge mclk) disable iff (reset)
    exec_go && eff_op == OP_FDEC |=>
      (($past(dest_b) ? file_mem[$past(faddr)] : w_reg) == $past(fval) - ONE8);
  endproperty
  a_fdec: assert property (p_fdec) else $error("decrement result wrong");

  // Timeout may drop from a counter overflow in the same cycle, so only zero and powerdown are held here
  property p_dsz;
    @(posedge mclk) disable iff (reset)
    exec_go && eff_op == OP_DSKIP |=> $stable(zero_reg) && $stable(powerdown_reg) &&
      (($past(dest_b) ? file_mem[$past(faddr)] : w_reg) == $past(fval) - ONE8);
  endproperty
  a_dsz: assert property (p_dsz) else $error("decrement-skip wrong");

  property p_skip;
    @(posedge mclk) disable iff (reset)
    exec_go && skip_reg |=> pc_reg == $past(pc_reg) + PC_INC && $stable(w_reg) && $stable(zero_reg) && !skip_reg;
  endproperty
  a_skip: assert property (p_skip) else $error("skipped instruction not discarded");

  property p_skip_set;
    @(posedge mclk) disable iff (reset)
    exec_go && eff_op == OP_DSKIP |=> skip_reg == ($past(fval) == ONE8);
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip decision wrong");

  property p_zflag;
    @(posedge mclk) disable iff (reset)
    exec_go && (eff_op == OP_INV || eff_op == OP_FDEC) |=> zero_reg == $past(res_zero);
  endproperty
  a_zflag: assert property (p_zflag) else $error("zero flag wrong");

  property p_wait;
    @(posedge mclk) disable iff (reset)
    req && wait_reg && !stall |=> !wait_reg ##1 wait_reg;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer timing wrong");
endmodule
`default_nettype wire

// ### hw/cise_stack.sv
// Circular hardware return stack
`timescale 1ns/10ps
`default_nettype none
module cise_stack
  import cise_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic   mclk,
  input  wire logic   reset,
  cise_stack_if.stack sif
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [PC_W-1:0]  mem [DEPTH];
  logic [PTR_W-1:0] ptr_reg;
  logic [PTR_W-1:0] ptr_next;

  assign ptr_next      = ptr_reg + 1'b1;
  assign sif.stack_top = mem[ptr_reg];

  // Oldest entry is overwritten once all levels are in use
  always_ff @(posedge mclk) begin
    if (reset) begin
      ptr_reg <= '0;
    end else if (sif.push) begin
      ptr_reg <= ptr_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= PC_RST;
      end
    end else if (sif.push) begin
      mem[ptr_next] <= sif.push_addr;
    end
  end
endmodule
`default_nettype wire

// ### include/cise_pkg.sv
// Shared constants and types for the instruction subset execution block
`default_nettype none
package cise_pkg;
  localparam int DATA_W       = 8;
  localparam int PC_W         = 15;
  localparam int FADR_W       = 7;
  localparam int LATCH_W      = 7;
  localparam int BUS_AW       = 10;
  localparam int BUS_DW       = 32;

  typedef enum logic [3:0] {
    OP_NOP    = 4'h0,
    OP_DOGCLR = 4'h1,
    OP_WCALL  = 4'h2,
    OP_INV    = 4'h3,
    OP_FCLR   = 4'h4,
    OP_FDEC   = 4'h5,
    OP_WCLR   = 4'h6,
    OP_DSKIP  = 4'h7
  } cise_op_t;

  // Register byte addresses
  localparam logic [BUS_AW-1:0] OFF_INSTR  = 10'h000;
  localparam logic [BUS_AW-1:0] OFF_STATUS = 10'h004;
  localparam logic [BUS_AW-1:0] OFF_WREG   = 10'h008;
  localparam logic [BUS_AW-1:0] OFF_LATCH  = 10'h00C;
  localparam logic [BUS_AW-1:0] OFF_PC     = 10'h010;
  localparam logic [BUS_AW-1:0] OFF_TOP    = 10'h014;
  localparam logic [BUS_AW-1:0] OFF_DOG    = 10'h018;
  localparam int FILE_SEL_BIT = 9;
  localparam int FILE_IDX_LSB = 2;

  // Instruction word fields
  localparam int OP_LSB   = 0;
  localparam int OP_W     = 4;
  localparam int DEST_BIT = 7;
  localparam int FADR_LSB = 8;

  // Status word bits
  localparam int ST_ZERO = 0;
  localparam int ST_PDN  = 1;
  localparam int ST_TMO  = 2;
  localparam int ST_SKIP = 3;
  localparam int ST_BUSY = 4;

  // Values after reset and constants
  localparam logic [DATA_W-1:0]  ZERO8      = 8'h00;
  localparam logic [DATA_W-1:0]  ONE8       = 8'h01;
  localparam logic [LATCH_W-1:0] LATCH_RST  = 7'h00;
  localparam logic [PC_W-1:0]    PC_RST     = 15'h0000;
  localparam logic [PC_W-1:0]    PC_INC     = 15'h0001;
  localparam logic               Z_RST      = 1'b0;
  localparam logic               TMO_RST    = 1'b1;
  localparam logic               PDN_RST    = 1'b1;
  localparam logic [BUS_DW-1:0]  RD_ZERO    = 32'h0000_0000;
endpackage
`default_nettype wire

// ### include/cise_stack_if.sv
// Push port and top-of-stack view between the core and its return stack
`timescale 1ns/10ps
`default_nettype none
interface cise_stack_if;
  import cise_pkg::*;
  logic            push;
  logic [PC_W-1:0] push_addr;
  logic [PC_W-1:0] stack_top;
  modport core  (output push, output push_addr, input stack_top);
  modport stack (input push, input push_addr, output stack_top);
endinterface
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the instruction subset execution core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cise_pkg::*;

  typedef struct packed {
    logic [3:0] op;
    logic       d;
    logic [6:0] f;
    logic       pre_z;
    logic [7:0] init;
    logic [7:0] res;
    logic       z;
  } cise_row_t;

  localparam logic [3:0]        op_nop    = 4'h0;
  localparam logic [3:0]        op_dogclr = 4'h1;
  localparam logic [3:0]        op_wcall  = 4'h2;
  localparam logic [3:0]        op_inv    = 4'h3;
  localparam logic [3:0]        op_fclr   = 4'h4;
  localparam logic [3:0]        op_fdec   = 4'h5;
  localparam logic [3:0]        op_wclr   = 4'h6;
  localparam logic [3:0]        op_dskip  = 4'h7;
  localparam logic [BUS_AW-1:0] adr_latch = 10'h00C;
  localparam logic [BUS_AW-1:0] adr_top   = 10'h014;
  localparam logic [BUS_AW-1:0] adr_dog   = 10'h018;
  localparam logic [BUS_AW-1:0] adr_none  = 10'h01C;

  logic              mclk;
  logic              reset;
  logic [BUS_AW-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [BUS_DW-1:0] avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [BUS_DW-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic [PC_W-1:0]   pc_out;
  logic              zero_flag;
  logic              timeout_flag;
  logic              powerdown_flag;
  int                err_count;
  int                samples_checked;
  int                cycles;
  logic [PC_W-1:0]   exp_pc;
  logic [PC_W-1:0]   call_tgt;
  logic [PC_W-1:0]   ret_pc;
  logic [31:0]       rd;
  cise_row_t         r;
  cise_row_t         rows [8];

  // Short prescaler and counter so a timeout is reached within a few dozen cycles
  cise_core #(.STACK_DEPTH(16), .PRE_W(2), .DOG_W(2)) uut (
    .mclk            (mclk),
    .reset           (reset),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .pc_out          (pc_out),
    .zero_flag       (zero_flag),
    .timeout_flag    (timeout_flag),
    .powerdown_flag  (powerdown_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Hold the request until the edge that samples waitrequest low
  task automatic bus_cycle(input logic wr, input logic [BUS_AW-1:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    if (n >= 20) begin
      err_count++;
      test_done();
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic bus_write(input logic [BUS_AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_cycle(1'b1, a, d, q);
  endtask

  task automatic bus_read(input logic [BUS_AW-1:0] a, output logic [31:0] q);
    bus_cycle(1'b0, a, 32'h0000_0000, q);
  endtask

  function automatic logic [BUS_AW-1:0] file_adr(input logic [6:0] f);
    return {1'b1, f, 2'b00};
  endfunction

  task automatic exec(input logic [3:0] op, input logic d, input logic [6:0] f);
    bus_write(OFF_INSTR, {17'h0_0000, f, d, 3'h0, op});
    #1;
    exp_pc = (op == op_wcall) ? call_tgt : exp_pc + 15'h0001;
    chk_word("pc", {17'h0_0000, exp_pc}, {17'h0_0000, pc_out});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{op_inv, 1'b0, 7'h00, 1'b1, 8'h0F, 8'hF0, 1'b0};
    rows[1] = '{op_inv, 1'b1, 7'h7F, 1'b0, 8'hFF, 8'h00, 1'b1};
    rows[2] = '{op_fclr, 1'b1, 7'h09, 1'b0, 8'hA5, 8'h00, 1'b1};
    rows[3] = '{op_fdec, 1'b0, 7'h14, 1'b0, 8'h01, 8'h00, 1'b1};
    rows[4] = '{op_fdec, 1'b1, 7'h40, 1'b1, 8'h00, 8'hFF, 1'b0};
    rows[5] = '{op_wclr, 1'b0, 7'h0A, 1'b0, 8'h33, 8'h00, 1'b1};
    rows[6] = '{op_dskip, 1'b1, 7'h1E, 1'b1, 8'h05, 8'h04, 1'b1};
    rows[7] = '{op_dskip, 1'b0, 7'h1F, 1'b0, 8'h80, 8'h7F, 1'b0};
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    exp_pc = 15'h0000;
    call_tgt = 15'h0000;
    reset = 1'b1;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk_bit("waitrequest", 1'b1, avs_waitrequest);
    chk_word("pc", 32'h0000_0000, {17'h0_0000, pc_out});
    chk_bit("zero", 1'b0, zero_flag);
    chk_bit("timeout", 1'b1, timeout_flag);
    chk_bit("powerdown", 1'b1, powerdown_flag);
    @(posedge mclk);
    bus_read(OFF_STATUS, rd);
    chk_word("status", 32'h0000_0006, rd);
    bus_read(OFF_WREG, rd);
    chk_word("w", 32'h0000_0000, rd);
    bus_read(adr_latch, rd);
    chk_word("latch", 32'h0000_0000, rd);
    $display("test reset done");

    // Each row: preset the zero flag, load W with a marker, run one instruction
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      bus_write(file_adr(r.f), {24'h00_0000, r.init});
      if (r.pre_z) begin
        exec(op_wclr, 1'b0, 7'h00);
      end else begin
        bus_write(file_adr(7'h7E), 32'h0000_0010);
        exec(op_inv, 1'b0, 7'h7E);
      end
      bus_write(OFF_WREG, 32'h0000_005A);
      exec(r.op, r.d, r.f);
      chk_bit("zero", r.z, zero_flag);
      bus_read(OFF_WREG, rd);
      chk_word("w", r.d ? 32'h0000_005A : {24'h00_0000, r.res}, rd);
      bus_read(file_adr(r.f), rd);
      chk_word("file", r.d ? {24'h00_0000, r.res} : {24'h00_0000, r.init}, rd);
    end
    $display("test table done");

    bus_write(file_adr(7'h7E), 32'h0000_0010);
    exec(op_inv, 1'b0, 7'h7E);
    bus_write(adr_latch, 32'h0000_0055);
    bus_write(OFF_WREG, 32'h0000_00A3);
    ret_pc = exp_pc + 15'h0001;
    call_tgt = 15'h55A3;
    exec(op_wcall, 1'b0, 7'h00);
    chk_bit("zero", 1'b0, zero_flag);
    chk_bit("powerdown", 1'b1, powerdown_flag);
    bus_read(adr_top, rd);
    chk_word("stack top", {17'h0_0000, ret_pc}, rd);
    exec(op_nop, 1'b0, 7'h00);
    $display("test call done");

    bus_write(file_adr(7'h03), 32'h0000_0001);
    bus_write(file_adr(7'h04), 32'h0000_0077);
    bus_write(file_adr(7'h05), 32'h0000_0077);
    exec(op_dskip, 1'b1, 7'h03);
    bus_read(OFF_STATUS, rd);
    chk_bit("skip pending", 1'b1, rd[ST_SKIP]);
    chk_bit("zero", 1'b0, zero_flag);
    exec(op_fclr, 1'b1, 7'h04);
    exec(op_fclr, 1'b1, 7'h05);
    bus_read(file_adr(7'h03), rd);
    chk_word("file", 32'h0000_0000, rd);
    bus_read(file_adr(7'h04), rd);
    chk_word("discarded file", 32'h0000_0077, rd);
    bus_read(file_adr(7'h05), rd);
    chk_word("file", 32'h0000_0000, rd);
    $display("test skip done");

    repeat (40) @(posedge mclk);
    #1;
    chk_bit("timeout", 1'b0, timeout_flag);
    exec(op_dogclr, 1'b0, 7'h00);
    chk_bit("timeout", 1'b1, timeout_flag);
    chk_bit("powerdown", 1'b1, powerdown_flag);
    bus_read(adr_dog, rd);
    chk_word("watchdog", 32'h0000_0000, rd);
    $display("test watchdog done");

    bus_read(adr_none, rd);
    chk_word("unmapped", 32'h0000_0000, rd);
    bus_write(OFF_PC, 32'h0000_1234);
    #1;
    chk_word("pc", {17'h0_0000, exp_pc}, {17'h0_0000, pc_out});
    bus_read(OFF_PC, rd);
    chk_word("pc read", {17'h0_0000, exp_pc}, rd);
    // An instruction write without lane 1 must be ignored
    avs_byteenable <= 4'h1;
    bus_write(OFF_INSTR, 32'h0000_0006);
    avs_byteenable <= 4'hF;
    #1;
    chk_word("pc", {17'h0_0000, exp_pc}, {17'h0_0000, pc_out});
    bus_read(OFF_WREG, rd);
    chk_word("w", 32'h0000_00A3, rd);
    $display("test refusal done");

    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk_word("pc", 32'h0000_0000, {17'h0_0000, pc_out});
    chk_bit("timeout", 1'b1, timeout_flag);
    bus_read(OFF_WREG, rd);
    chk_word("w", 32'h0000_0000, rd);
    bus_read(OFF_STATUS, rd);
    chk_word("status", 32'h0000_0006, rd);
    $display("test reset again done");
    test_done();
  end
endmodule
`default_nettype wire
